// [common/idp_defines.vh]
// constants for the interrupt dispatch and power-mode block
// assumes a twelve-clock machine cycle core and 32-bit apb register access
`ifndef IDP_DEFINES_VH
`define IDP_DEFINES_VH
`define IDP_NSRC 10
`define IDP_PHASES 4'hC
`define IDP_PHASE_LAST 4'hB
`define IDP_PHASE_SAMPLE 4'h9
`define IDP_RST_WAIT 2'h3
`define IDP_EXT_RST_MC 2'h2
// register byte addresses: power_control printed offset 87 is an index
`define IDP_IDX_POWER_CONTROL 8'h87
`define IDP_ADDR_POWER_CONTROL 12'h21C
`define IDP_ADDR_IRQ_ENABLE 12'h000
`define IDP_ADDR_IRQ_PRIORITY 12'h004
`define IDP_ADDR_STATUS 12'h008
`define IDP_ADDR_VECTOR 12'h00C
`define IDP_POWER_CONTROL_RESET 8'h00
`define IDP_IE_RESET 11'h000
`define IDP_IP_RESET 10'h000
`define IDP_BIT_IDLE 0
`define IDP_BIT_PDOWN 1
`define IDP_BIT_ADCIRQ 4
`define IDP_BIT_LVRDIS 5
`define IDP_BIT_SER1DBL 7
`define IDP_BIT_SER2DBL 6
`define IDP_BIT_SER2RX 3
`define IDP_BIT_SER2TX 2
`define IDP_BIT_GIE 10
// vectors in polling order: int0, serial2, timer0, i2c, int1, ddc, timer1,
// usb, serial1, timer2
`define IDP_VECTORS 160'h0003_004B_000B_0043_0013_003B_001B_0033_0023_002B
`endif

// [design/idp_cycle_timer.v]
// machine-cycle phase counter
// assumes one clock per oscillator period, twelve per machine cycle
`timescale 1ns/1ps
module idp_cycle_timer (
    clk,
    sys_rst,
    clkEn,
    samplePulse,
    lastPulse
);
`include "idp_defines.vh"
input wire clk;
input wire sys_rst;
input wire clkEn;
output wire samplePulse;
output wire lastPulse;
reg [3:0] phase_ff;
wire [3:0] nxt_phase;
assign nxt_phase = (phase_ff == `IDP_PHASE_LAST) ? 4'h0 : phase_ff + 4'h1;
always @(posedge clk) begin
    if (sys_rst) begin
        phase_ff <= 4'h0;
    end else if (clkEn) begin
        phase_ff <= nxt_phase;
    end
end
assign samplePulse = clkEn && (phase_ff == `IDP_PHASE_SAMPLE);
assign lastPulse = clkEn && (phase_ff == `IDP_PHASE_LAST);
endmodule

// [design/idp_priority_pick.v]
// fixed-order pick of the first pending source at a given level
// assumes request bits ordered by polling sequence, bit 0 first
`timescale 1ns/1ps
module idp_priority_pick (
    req,
    found,
    index
);
`include "idp_defines.vh"
parameter N = `IDP_NSRC;
input wire [N-1:0] req;
output reg found;
output reg [3:0] index;
integer i;
always @* begin
    found = 1'b0;
    index = 4'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
        if (req[i]) begin
            found = 1'b1;
            index = i[3:0];
        end
    end
end
endmodule

// [design/idp_interrupt_dispatch.v]
// interrupt dispatch and power-mode control with apb register access
// assumes the core reports instruction boundaries and returns, synchronous
// flags from on-chip peripherals and a pin-level external reset request
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - sample flags each cycle, poll next cycle; here the sample is polled at the last phase of its own cycle
// - unblocked pending flag issues hardware vector call
// - block while equal or higher level active
// - call only in final instruction cycle
// - block during return or enable/priority access
// - denied requests are not remembered
// - push pc, no status save, load vector
// - vectors 001Bh, 0023h, 002Bh for t1/serial1/t2
// - return clears level in-progress, pops pc
// - plain return keeps in-progress state set
// - idle halts only cpu, peripherals run
// - enabled interrupt clears idle and is serviced
// - internal reset restarts after three cycles
// - power-down stops clock, keeps state
// - power-down disables units, detector stays on
// - only reset leaves power-down
// - power control reset zero, bit layout
// - one priority bit per source, fixed order
// - per-source enable and global enable
module idp_interrupt_dispatch (
    clk,
    sys_rst,
    clkEn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    irqFlags,
    instrLast,
    instrIsReti,
    instrIrqRegAccess,
    extRstReq,
    intRstReq,
    hwVectorCall,
    pushPc,
    vectorAddr,
    cpuHalt,
    cpuRestart,
    oscStop,
    unitsDisable,
    lowvoltDetectorOn,
    lowvoltResetDisable,
    serial1DoubleRate,
    serial2DoubleRate,
    converterIrqEnable,
    serial2RxClockSelect,
    serial2TxClockSelect
);
`include "idp_defines.vh"
parameter N = `IDP_NSRC;
input wire clk;
input wire sys_rst;
input wire clkEn;
input wire psel;
input wire penable;
input wire pwrite;
input wire [11:0] paddr;
input wire [31:0] pwdata;
output reg [31:0] prdata;
output reg pready;
output reg pslverr;
input wire [N-1:0] irqFlags;
input wire instrLast;
input wire instrIsReti;
input wire instrIrqRegAccess;
input wire extRstReq;
input wire intRstReq;
output reg hwVectorCall;
output reg pushPc;
output reg [15:0] vectorAddr;
output reg cpuHalt;
output reg cpuRestart;
output reg oscStop;
output reg unitsDisable;
output reg lowvoltDetectorOn;
output reg lowvoltResetDisable;
output reg serial1DoubleRate;
output reg serial2DoubleRate;
output reg converterIrqEnable;
output reg serial2RxClockSelect;
output reg serial2TxClockSelect;

////////////////////////////////////////////////////////////////////////////////
// state
reg [7:0] powerControl_ff;
reg [10:0] irqEnable_ff;
reg [9:0] irqPriority_ff;
reg [N-1:0] sampled_ff;
reg inProgHigh_ff;
reg inProgLow_ff;
reg [15:0] lastVector_ff;
reg [1:0] extRstSync_ff;
reg [1:0] extRstCnt_ff;
reg [1:0] restartCnt_ff;
reg restartPending_ff;
wire samplePulse;
wire lastPulse;
wire apbWrite;
wire apbRead;
wire [N-1:0] pending;
wire [N-1:0] pendHigh;
wire [N-1:0] pendLow;
wire foundHigh;
wire foundLow;
wire [3:0] idxHigh;
wire [3:0] idxLow;
wire blocked;
wire takeHigh;
wire takeLow;
wire [3:0] takeIdx;
wire [159:0] vecTable;
reg [15:0] vecSel;
reg [31:0] nxt_prdata;
reg nxt_pslverr;
integer k;

// the oscillator stop also stops this block's timer, sampling and calls; reset paths, apb and enable/priority register writes keep running
wire runEn;
assign runEn = clkEn && !powerControl_ff[`IDP_BIT_PDOWN];

idp_cycle_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(runEn),
    .samplePulse(samplePulse),
    .lastPulse(lastPulse)
);

////////////////////////////////////////////////////////////////////////////////
// sampling and polling
always @(posedge clk) begin
    if (sys_rst) begin
        sampled_ff <= {N{1'b0}};
    end else if (samplePulse) begin
        sampled_ff <= irqFlags;
    end
end

// mapping of enable bits onto polling order
wire [N-1:0] srcEnable;
wire [N-1:0] srcPrio;
assign srcEnable = {irqEnable_ff[5], irqEnable_ff[4], irqEnable_ff[8],
    irqEnable_ff[3], irqEnable_ff[7], irqEnable_ff[2], irqEnable_ff[9],
    irqEnable_ff[1], irqEnable_ff[6], irqEnable_ff[0]};
assign srcPrio = {irqPriority_ff[5], irqPriority_ff[4], irqPriority_ff[8],
    irqPriority_ff[3], irqPriority_ff[7], irqPriority_ff[2], irqPriority_ff[9],
    irqPriority_ff[1], irqPriority_ff[6], irqPriority_ff[0]};
// no latch of denied requests: only the current sample counts
assign pending = sampled_ff & srcEnable & {N{irqEnable_ff[`IDP_BIT_GIE]}};
assign pendHigh = pending & srcPrio;
assign pendLow = pending & ~srcPrio;

idp_priority_pick #(.N(N)) u_pick_high (
    .req(pendHigh),
    .found(foundHigh),
    .index(idxHigh)
);
idp_priority_pick #(.N(N)) u_pick_low (
    .req(pendLow),
    .found(foundLow),
    .index(idxLow)
);

assign blocked = !instrLast || instrIsReti || instrIrqRegAccess;
assign takeHigh = foundHigh && !inProgHigh_ff;
assign takeLow = foundLow && !inProgHigh_ff && !inProgLow_ff;
assign takeIdx = takeHigh ? idxHigh : idxLow;
assign vecTable = `IDP_VECTORS;

always @* begin
    vecSel = 16'h0000;
    for (k = 0; k < N; k = k + 1) begin
        if (takeIdx == k[3:0]) begin
            vecSel = vecTable[159 - 16 * k -: 16];
        end
    end
end

wire grant;
assign grant = lastPulse && !blocked && (takeHigh || takeLow);

////////////////////////////////////////////////////////////////////////////////
// in-progress levels and call outputs
always @(posedge clk) begin
    if (sys_rst) begin
        inProgHigh_ff <= 1'b0;
        inProgLow_ff <= 1'b0;
        hwVectorCall <= 1'b0;
        pushPc <= 1'b0;
        vectorAddr <= 16'h0000;
        lastVector_ff <= 16'h0000;
    end else if (runEn) begin
        hwVectorCall <= grant;
        pushPc <= grant;
        if (grant) begin
            vectorAddr <= vecSel;
            lastVector_ff <= vecSel;
            if (takeHigh) begin
                inProgHigh_ff <= 1'b1;
            end else begin
                inProgLow_ff <= 1'b1;
            end
        end else if (lastPulse && instrIsReti) begin
            // a plain return never reaches here, so the level stays busy
            if (inProgHigh_ff) begin
                inProgHigh_ff <= 1'b0;
            end else begin
                inProgLow_ff <= 1'b0;
            end
        end
    end else begin
        hwVectorCall <= 1'b0;
        pushPc <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// reset timing: pin reset synchronised and qualified over two machine cycles, or over two clocks in power-down
always @(posedge clk) begin
    if (sys_rst) begin
        extRstSync_ff <= 2'h0;
    end else begin
        extRstSync_ff <= {extRstSync_ff[0], extRstReq};
    end
end

wire extRstDone;
assign extRstDone = (extRstCnt_ff == `IDP_EXT_RST_MC);
wire rstEvent;
assign rstEvent = extRstDone || (intRstReq && !restartPending_ff);

always @(posedge clk) begin
    if (sys_rst) begin
        extRstCnt_ff <= 2'h0;
        restartCnt_ff <= 2'h0;
        restartPending_ff <= 1'b0;
        cpuRestart <= 1'b0;
    end else if (clkEn) begin
        cpuRestart <= 1'b0;
        if (!extRstSync_ff[1]) begin
            extRstCnt_ff <= 2'h0;
        // the cycle timer stops in power-down, so the pin reset counts clocks there
        end else if ((lastPulse || powerControl_ff[`IDP_BIT_PDOWN]) && !extRstDone) begin
            extRstCnt_ff <= extRstCnt_ff + 2'h1;
        end
        if (rstEvent && !restartPending_ff) begin
            restartPending_ff <= 1'b1;
            restartCnt_ff <= 2'h0;
        end else if (restartPending_ff && lastPulse) begin
            if (restartCnt_ff == `IDP_RST_WAIT - 2'h1) begin
                restartPending_ff <= 1'b0;
                cpuRestart <= 1'b1;
            end else begin
                restartCnt_ff <= restartCnt_ff + 2'h1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave, zero wait states
assign apbWrite = psel && penable && pwrite;
assign apbRead = psel && !penable && !pwrite;
wire addrOk;
assign addrOk = (paddr == `IDP_ADDR_POWER_CONTROL) || (paddr == `IDP_ADDR_IRQ_ENABLE)
    || (paddr == `IDP_ADDR_IRQ_PRIORITY) || (paddr == `IDP_ADDR_STATUS)
    || (paddr == `IDP_ADDR_VECTOR);

always @* begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = !addrOk;
    case (paddr)
        `IDP_ADDR_POWER_CONTROL: nxt_prdata = {24'h000000, powerControl_ff};
        `IDP_ADDR_IRQ_ENABLE: nxt_prdata = {21'h00000, irqEnable_ff};
        `IDP_ADDR_IRQ_PRIORITY: nxt_prdata = {22'h00000, irqPriority_ff};
        `IDP_ADDR_STATUS: nxt_prdata = {16'h0000, restartPending_ff, cpuHalt,
            inProgHigh_ff, inProgLow_ff, 2'h0, sampled_ff};
        `IDP_ADDR_VECTOR: nxt_prdata = {16'h0000, lastVector_ff};
        default: nxt_prdata = 32'h00000000;
    endcase
end

always @(posedge clk) begin
    if (sys_rst) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (clkEn) begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && nxt_pslverr;
        if (apbRead) begin
            prdata <= nxt_prdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// power control and enables; writes land in the access cycle
always @(posedge clk) begin
    if (sys_rst) begin
        powerControl_ff <= `IDP_POWER_CONTROL_RESET;
        irqEnable_ff <= `IDP_IE_RESET;
        irqPriority_ff <= `IDP_IP_RESET;
    end else if (clkEn) begin
        if (rstEvent) begin
            powerControl_ff <= `IDP_POWER_CONTROL_RESET;
        end else if (grant && powerControl_ff[`IDP_BIT_IDLE]) begin
            powerControl_ff[`IDP_BIT_IDLE] <= 1'b0;
        end else if (apbWrite && pready && paddr == `IDP_ADDR_POWER_CONTROL
            && !powerControl_ff[`IDP_BIT_PDOWN]) begin
            powerControl_ff <= pwdata[7:0];
        end
        if (apbWrite && pready && paddr == `IDP_ADDR_IRQ_ENABLE) begin
            irqEnable_ff <= pwdata[10:0];
        end
        if (apbWrite && pready && paddr == `IDP_ADDR_IRQ_PRIORITY) begin
            irqPriority_ff <= pwdata[9:0];
        end
    end
end

// mode outputs; idle only halts the cpu, all other units keep their clocks
always @(posedge clk) begin
    if (sys_rst) begin
        cpuHalt <= 1'b0;
        oscStop <= 1'b0;
        unitsDisable <= 1'b0;
        lowvoltDetectorOn <= 1'b1;
        lowvoltResetDisable <= 1'b0;
        serial1DoubleRate <= 1'b0;
        serial2DoubleRate <= 1'b0;
        converterIrqEnable <= 1'b0;
        serial2RxClockSelect <= 1'b0;
        serial2TxClockSelect <= 1'b0;
    end else if (clkEn) begin
        cpuHalt <= powerControl_ff[`IDP_BIT_IDLE] || powerControl_ff[`IDP_BIT_PDOWN];
        oscStop <= powerControl_ff[`IDP_BIT_PDOWN];
        unitsDisable <= powerControl_ff[`IDP_BIT_PDOWN];
        lowvoltDetectorOn <= 1'b1;
        lowvoltResetDisable <= powerControl_ff[`IDP_BIT_LVRDIS];
        serial1DoubleRate <= powerControl_ff[`IDP_BIT_SER1DBL];
        serial2DoubleRate <= powerControl_ff[`IDP_BIT_SER2DBL];
        converterIrqEnable <= powerControl_ff[`IDP_BIT_ADCIRQ];
        serial2RxClockSelect <= powerControl_ff[`IDP_BIT_SER2RX];
        serial2TxClockSelect <= powerControl_ff[`IDP_BIT_SER2TX];
    end
end
endmodule

// [testbench/idp_dispatch_asserts.sv]
// assertions on the dispatch block ports
// assumes a bind from the bench and a single clock domain
`timescale 1ns/1ps
module idp_dispatch_asserts #(parameter N = 10) (
    input wire clk,
    input wire sys_rst,
    input wire clkEn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [N-1:0] irqFlags,
    input wire instrLast,
    input wire instrIsReti,
    input wire instrIrqRegAccess,
    input wire intRstReq,
    input wire hwVectorCall,
    input wire pushPc,
    input wire [15:0] vectorAddr,
    input wire oscStop,
    input wire unitsDisable,
    input wire lowvoltDetectorOn,
    input wire cpuRestart
);
////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
sequence apbSetup;
    psel && !penable && clkEn ##1 clkEn;
endsequence
sequence callSeen;
    hwVectorCall && pushPc;
endsequence
a_call_push: assert property (hwVectorCall == pushPc)
    else $error("call and push differ");
a_call_spacing: assert property (callSeen |=> (!hwVectorCall)[*8])
    else $error("calls too close");
a_call_boundary: assert property (callSeen |-> $past(instrLast))
    else $error("call off instruction end");
a_call_unblocked: assert property (callSeen |-> !$past(instrIsReti)
    && !$past(instrIrqRegAccess))
    else $error("call during blocked instruction");
a_flag_cause: assert property (callSeen |-> $past(irqFlags, 3) != '0)
    else $error("call without sampled flag");
a_vector_legal: assert property (callSeen |-> vectorAddr[2:0] == 3'h3
    && vectorAddr <= 16'h004B)
    else $error("bad vector");
a_vector_held: assert property (!hwVectorCall |-> $stable(vectorAddr))
    else $error("vector moved without call");
a_apb_answer: assert property (apbSetup |-> pready)
    else $error("no ready in access cycle");
a_ready_pulse: assert property (pready |=> !pready && !pslverr)
    else $error("ready longer than one cycle");
a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
a_pd_units: assert property (oscStop |-> unitsDisable && lowvoltDetectorOn)
    else $error("units live in power-down");
a_pd_no_call: assert property (oscStop |-> !hwVectorCall)
    else $error("call in power-down");
a_restart_time: assert property (intRstReq |-> ##[20:40] cpuRestart)
    else $error("no restart after internal reset");
endmodule

// [testbench/idp_core_model.sv]
// core model: instruction ends, returns and call stack depth
// assumes its machine cycle starts with the block's at reset release
`timescale 1ns/1ps
module idp_core_model (
    input wire clk,
    input wire sys_rst,
    input wire slow,
    input wire retiReq,
    input wire hwVectorCall,
    output reg instrLast,
    output reg instrIsReti,
    output reg [3:0] depth
);
////////////////////////////////////////
reg [3:0] phase_ff;
wire cycEnd = (phase_ff == 4'hB);
always @(posedge clk) begin
    if (sys_rst) begin
        phase_ff <= 4'h0;
        instrLast <= 1'b1;
        instrIsReti <= 1'b0;
        depth <= 4'h0;
    end else begin
        phase_ff <= cycEnd ? 4'h0 : phase_ff + 4'h1;
        if (cycEnd) begin
            // slow: two-cycle instructions, so only every other end is final
            instrLast <= slow ? !instrLast : 1'b1;
            instrIsReti <= retiReq;
        end
        if (hwVectorCall) begin
            depth <= depth + 4'h1;
        end else if (instrIsReti && instrLast && cycEnd) begin
            depth <= depth - 4'h1;
        end
    end
end
endmodule

// [testbench/idp_tb.sv]
// bench: apb registers, irq flags and resets; core model answers calls
// assumes design, checker and core model are compiled first
`timescale 1ns/1ps
`include "idp_defines.vh"
module tb;
localparam [159:0] VT = `IDP_VECTORS;
localparam [11:0] PC = `IDP_ADDR_POWER_CONTROL;
reg clk = 1'b0;
reg sysRst = 1'b1;
reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, seed = 32'h5353, rd;
reg [9:0] flags = 10'h000;
reg regAcc = 1'b0, extRst = 1'b0, intRst = 1'b0, slow = 1'b0, return_from_interrupt = 1'b0;
reg clkEn = 1'b1;
reg [15:0] expQ[$];
wire [31:0] prdata;
wire [15:0] vec;
wire [5:0] cfg;
wire [3:0] depth;
wire pready, pslverr, call, halt, osc, units, iLast, iReti, push, lowvolt_detector, restart;
integer mismatches = 0, checksDone = 0, cycles = 0, i, restarts = 0;
idp_interrupt_dispatch idp_interrupt_dispatch_i (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqFlags(flags),
    .instrLast(iLast), .instrIsReti(iReti), .instrIrqRegAccess(regAcc),
    .extRstReq(extRst), .intRstReq(intRst), .hwVectorCall(call), .pushPc(push),
    .vectorAddr(vec), .cpuHalt(halt), .cpuRestart(restart), .oscStop(osc),
    .unitsDisable(units), .lowvoltDetectorOn(lowvolt_detector), .serial1DoubleRate(cfg[5]),
    .serial2DoubleRate(cfg[4]), .lowvoltResetDisable(cfg[3]),
    .converterIrqEnable(cfg[2]), .serial2RxClockSelect(cfg[1]),
    .serial2TxClockSelect(cfg[0]));
idp_core_model idp_core_model_i (.clk(clk), .sys_rst(sysRst), .slow(slow),
    .retiReq(return_from_interrupt), .hwVectorCall(call), .instrLast(iLast), .instrIsReti(iReti),
    .depth(depth));
////////////////////////////////////////
initial begin
    forever #12.5 clk = ~clk;
end
function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
endfunction
task chk(input [31:0] got, input [31:0] exp);
    begin
        checksDone = checksDone + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    end
endtask
task giveVerdict;
    begin
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
endtask
task waitMc(input integer n);
    repeat (12 * n) @(posedge clk);
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // ready, error and read data are all taken at the edge that sees ready high
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n = n + 1;
        end
        if (n >= 50)
            mismatches = mismatches + 1;
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // two edges more so registered mode outputs have settled for the caller
        repeat (2) @(posedge clk);
    end
endtask
task waitCall;
    integer n;
    begin
        n = 0;
        while (expQ.size() != 0 && n < 100) begin
            @(posedge clk);
            n = n + 1;
        end
        chk(expQ.size(), 32'h0);
        expQ.delete();
    end
endtask
task retire;
    begin
        return_from_interrupt <= 1'b1;
        waitMc(1);
        return_from_interrupt <= 1'b0;
    end
endtask
// expected vector is that of the lowest set flag, the first one polled
task serve(input [9:0] f);
    integer j, k;
    begin
        k = 0;
        for (j = 9; j >= 0; j = j - 1)
            if (f[j]) k = j;
        expQ.push_back(VT[159 - 16 * k -: 16]);
        flags <= f;
        waitCall;
        flags <= 10'h000;
        retire;
    end
endtask
always @(negedge clk) begin
    if (restart === 1'b1)
        restarts = restarts + 1;
    if (call === 1'b1) begin
        if (expQ.size() == 0)
            chk(32'h1, 32'h0);
        else
            chk({15'h0, push, vec}, {15'h0, 1'b1, expQ.pop_front()});
    end
end
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
        mismatches = mismatches + 1;
        giveVerdict;
    end
end
initial begin
    repeat (10) @(posedge clk);
    sysRst <= 1'b0;
    apb(0, PC, 0);
    chk(rd, 32'h0);
    apb(1, PC, 32'hA4);
    chk({26'h0, cfg}, 32'h29);
    apb(0, PC, 0);
    chk(rd, 32'hA4);
    apb(0, 12'h100, 0);
    chk({31'h0, err}, 32'h1);
    extRst <= 1'b1;
    waitMc(3);
    extRst <= 1'b0;
    waitMc(1);
    apb(0, PC, 0);
    chk(rd, 32'h0);
    apb(1, `IDP_ADDR_IRQ_ENABLE, 32'h3FF);
    flags <= 10'h3FF;
    waitMc(3);
    flags <= 10'h000;
    // let a clean sample replace the stale one before interrupts are opened
    waitMc(1);
    apb(1, `IDP_ADDR_IRQ_ENABLE, 32'h440);
    serve(10'h082);
    apb(1, `IDP_ADDR_IRQ_ENABLE, 32'h7FF);
    for (i = 0; i < 10; i = i + 1)
        serve(10'h001 << i);
    for (i = 0; i < 4; i = i + 1) begin
        seed = xs(seed);
        serve(seed[9:0] | 10'h200);
    end
    expQ.push_back(16'h0003);
    flags <= 10'h001;
    waitCall;
    flags <= 10'h004;
    waitMc(3);
    expQ.push_back(16'h000B);
    retire;
    waitCall;
    flags <= 10'h000;
    retire;
    regAcc <= 1'b1;
    flags <= 10'h010;
    waitMc(3);
    flags <= 10'h000;
    waitMc(1);
    regAcc <= 1'b0;
    waitMc(3);
    // a frozen block must not sample; one whole machine cycle keeps phases aligned
    clkEn <= 1'b0;
    flags <= 10'h001;
    waitMc(1);
    flags <= 10'h000;
    clkEn <= 1'b1;
    waitMc(2);
    expQ.push_back(16'h001B);
    slow <= 1'b1;
    flags <= 10'h040;
    waitCall;
    flags <= 10'h000;
    slow <= 1'b0;
    retire;
    apb(1, PC, 32'h01);
    chk({30'h0, halt, units}, 32'h2);
    serve(10'h002);
    chk({31'h0, halt}, 32'h0);
    apb(1, PC, 32'h02);
    chk({29'h0, osc, units, lowvolt_detector}, 32'h7);
    flags <= 10'h001;
    waitMc(3);
    flags <= 10'h000;
    intRst <= 1'b1;
    @(posedge clk);
    intRst <= 1'b0;
    waitMc(4);
    chk({30'h0, osc, halt}, 32'h0);
    apb(0, PC, 0);
    chk(rd, 32'h0);
    chk({28'h0, depth}, 32'h0);
    chk(restarts, 2);
    giveVerdict;
end
endmodule
bind idp_interrupt_dispatch idp_dispatch_asserts #(.N(N)) idp_dispatch_asserts_i (
    .clk, .sys_rst, .clkEn, .psel, .penable, .pready, .pslverr, .irqFlags, .instrLast,
    .instrIsReti, .instrIrqRegAccess, .intRstReq, .hwVectorCall, .pushPc, .vectorAddr,
    .oscStop, .unitsDisable, .lowvoltDetectorOn, .cpuRestart);
